// File: rtl/dsm_regs.vh
`ifndef DSM_REGS_VH
`define DSM_REGS_VH
`define DSM_ADDR_LO 6
`define DSM_ADDR_HI 13
`define DSM_ADDR_W 8
`define DSM_LANES 8
`define DSM_ROW_STROBES 3
`define DSM_ROWS 8
`define DSM_SOCKET_W 2
`define DSM_SOCKET0 2'h0
`define DSM_CFG_ROW_DUP 1'b0
`define DSM_CFG_ADDR_COPY 1'b1
`define DSM_DUP_LANE_A 1
`define DSM_DUP_LANE_B 5
`define DSM_CMD_W 3
`define DSM_CMD_NOP 3'h7
`endif

// File: rtl/dsm_addr_copy.v
`timescale 1ns/1ps
`include "dsm_regs.vh"
module dsm_addr_copy (
    input wire clk,
    input wire resetn,
    input wire [`DSM_ADDR_W-1:0] next_addr,
    input wire sock0_cur,
    input wire sock0_next,
    output reg [`DSM_ADDR_W-1:0] addr_copy
);
    // Socket-0 copy follows the primary address only for socket-0 accesses
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_copy <= {`DSM_ADDR_W{1'b0}};
        end else if (sock0_cur || sock0_next) begin // [R2] [R4]
            addr_copy <= next_addr; // [R1]
        end
        // Otherwise held for sockets 1 to 3 [R3]
    end
endmodule

// File: rtl/dsm_strobe_out.v
`timescale 1ns/1ps
`include "dsm_regs.vh"
// Behaviour
// R1 - Config two: socket-zero copy carries primary address bits 13..6.
// R2 - Copy updates only when current or next access targets socket 0.
// R3 - Copy holds its value when neither the current nor the next access targets socket 0.
// R4 - Updated copy has the same timing as primary address bits.
// R5 - EDO rows: low-active column strobe lines latch the column address.
// R6 - SDRAM reads: column lines act as per-lane output enables.
// R7 - SDRAM writes: column lines act as per-byte write masks.
// R8 - Write mask appears in the same cycle as its write data.
// R9 - Extra output copies column line 1 exactly.
// R10 - Extra output copies column line 5 exactly.
// R11 - Three row strobe outputs carry one identical logical row strobe.
// R12 - SDRAM command encoded on row strobe, column strobe and write enable.
// R13 - SDRAM captures row address when row strobe sampled low on rising edge.
// R14 - Column, duplicate and row strobe outputs same in both configurations.
// R15 - Config one: copy pins carry duplicate row strobes or chip selects.
// R16 - Pin configuration is a static setting, fixed before accesses begin.
module dsm_strobe_out (
    input wire clk,
    input wire resetn,
    input wire pin_config,
    input wire row_is_sdram,
    input wire sdram_cmd_valid,
    input wire [`DSM_CMD_W-1:0] sdram_cmd,
    input wire edo_cas_active,
    input wire sdram_read,
    input wire sdram_write,
    input wire [`DSM_LANES-1:0] byte_enable,
    input wire [`DSM_ADDR_HI:0] primary_mem_addr_next,
    input wire [`DSM_SOCKET_W-1:0] cur_socket,
    input wire [`DSM_SOCKET_W-1:0] next_socket,
    input wire [`DSM_ROWS-1:0] row_select_next,
    output reg [`DSM_LANES-1:0] col_strobe_byte_mask_n,
    output reg col_strobe_mask_dup_lane1_n,
    output reg col_strobe_mask_dup_lane5_n,
    output reg [`DSM_ROW_STROBES-1:0] sdram_row_strobe_n,
    output reg logical_col_strobe_n,
    output reg write_enable_n,
    output reg [`DSM_ADDR_HI:0] primary_mem_addr,
    output reg [`DSM_ADDR_W-1:0] shared_copy_pins
);
    reg cfg;
    reg cfg_taken;
    reg [`DSM_LANES-1:0] next_mask;
    reg [`DSM_ROWS-1:0] row_select_dup_n;
    wire [`DSM_ADDR_W-1:0] socket0_addr_copy;

    // Configuration captured once after reset release and then frozen
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg <= `DSM_CFG_ROW_DUP;
            cfg_taken <= 1'b0;
        end else if (!cfg_taken) begin
            cfg <= pin_config; // [R16]
            cfg_taken <= 1'b1;
        end
    end

    always @* begin
        if (!row_is_sdram) begin
            next_mask = edo_cas_active ? {`DSM_LANES{1'b0}} : {`DSM_LANES{1'b1}}; // [R5]
        end else if (sdram_write) begin
            next_mask = ~byte_enable; // [R7]
        end else if (sdram_read) begin
            next_mask = ~byte_enable; // [R6]
        end else begin
            next_mask = {`DSM_LANES{1'b1}};
        end
    end

    // Mask registered on the same edge the write data launches
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            col_strobe_byte_mask_n <= {`DSM_LANES{1'b1}};
            col_strobe_mask_dup_lane1_n <= 1'b1;
            col_strobe_mask_dup_lane5_n <= 1'b1;
            sdram_row_strobe_n <= {`DSM_ROW_STROBES{1'b1}};
            logical_col_strobe_n <= 1'b1;
            write_enable_n <= 1'b1;
            primary_mem_addr <= {(`DSM_ADDR_HI+1){1'b0}};
            row_select_dup_n <= {`DSM_ROWS{1'b1}};
        end else begin
            col_strobe_byte_mask_n <= next_mask; // [R8] [R14]
            col_strobe_mask_dup_lane1_n <= next_mask[`DSM_DUP_LANE_A]; // [R9]
            col_strobe_mask_dup_lane5_n <= next_mask[`DSM_DUP_LANE_B]; // [R10]
            if (row_is_sdram && sdram_cmd_valid) begin
                sdram_row_strobe_n <= {`DSM_ROW_STROBES{sdram_cmd[2]}}; // [R11] [R12] [R13]
                logical_col_strobe_n <= sdram_cmd[1]; // [R12]
                write_enable_n <= sdram_cmd[0];
            end else begin
                sdram_row_strobe_n <= {`DSM_ROW_STROBES{1'b1}};
                logical_col_strobe_n <= 1'b1;
                write_enable_n <= 1'b1;
            end
            primary_mem_addr <= primary_mem_addr_next;
            row_select_dup_n <= ~row_select_next;
        end
    end

    dsm_addr_copy u_copy (
        .clk(clk),
        .resetn(resetn),
        .next_addr(primary_mem_addr_next[`DSM_ADDR_HI:`DSM_ADDR_LO]),
        .sock0_cur(cur_socket == `DSM_SOCKET0),
        .sock0_next(next_socket == `DSM_SOCKET0),
        .addr_copy(socket0_addr_copy)
    );

    always @* begin
        if (cfg == `DSM_CFG_ADDR_COPY) begin
            shared_copy_pins = socket0_addr_copy; // [R1]
        end else begin
            shared_copy_pins = row_select_dup_n; // [R15]
        end
    end
endmodule

// File: bench/dsm_strobe_out_asserts.sv
`timescale 1ns/1ps
module dsm_strobe_asserts (
    input logic clk, resetn, pin_config, row_is_sdram, edo_cas_active, sdram_read, sdram_write,
    input logic col_strobe_mask_dup_lane1_n, col_strobe_mask_dup_lane5_n,
    input logic [1:0] cur_socket, next_socket,
    input logic [2:0] sdram_row_strobe_n,
    input logic [7:0] byte_enable, row_select_next, col_strobe_byte_mask_n, shared_copy_pins,
    input logic [13:0] primary_mem_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Pin configuration as the block latches it: first edge after reset release
    logic cfg_seen, cfg_taken;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_seen <= 1'b0;
            cfg_taken <= 1'b0;
        end else if (!cfg_taken) begin
            cfg_seen <= pin_config;
            cfg_taken <= 1'b1;
        end
    end
    sequence s_sock0;
        cfg_seen && (cur_socket == 2'h0 || next_socket == 2'h0);
    endsequence
    chk_copy_track: assert property (
        s_sock0 |=> shared_copy_pins == primary_mem_addr[13:6]) else $error("copy");
    chk_copy_hold: assert property (
        cfg_seen && cur_socket != 2'h0 && next_socket != 2'h0 |=> $stable(shared_copy_pins))
        else $error("hold");
    chk_row_dup: assert property (
        cfg_taken && !cfg_seen |=> shared_copy_pins == ~$past(row_select_next))
        else $error("rowdup");
    chk_edo_cas: assert property (
        !row_is_sdram && edo_cas_active |=> col_strobe_byte_mask_n == 8'h00) else $error("cas");
    chk_mask_lane: assert property (
        row_is_sdram && (sdram_read || sdram_write) |=>
        col_strobe_byte_mask_n == ~$past(byte_enable)) else $error("mask");
    chk_row_same: assert property (
        sdram_row_strobe_n == {3{sdram_row_strobe_n[0]}}) else $error("ras");
    chk_dup_one: assert property (
        col_strobe_mask_dup_lane1_n == col_strobe_byte_mask_n[1]) else $error("dup1");
    chk_dup_five: assert property (
        col_strobe_mask_dup_lane5_n == col_strobe_byte_mask_n[5]) else $error("dup5");
endmodule
bind dsm_strobe_out dsm_strobe_asserts i_dsm_strobe_asserts (.*);

// File: bench/dsm_sdram_model.sv
`timescale 1ns/1ps
module dsm_sdram_model (
    input logic clk,
    input logic [2:0] row_strobe_n,
    input logic [13:0] addr,
    output logic [13:0] row_addr
);
    always @(posedge clk) if (!row_strobe_n[0]) row_addr <= addr;
endmodule

// File: bench/dsm_strobe_out_tb_top.sv
`timescale 1ns/1ps
module dsm_strobe_out_tb_top;
    logic clk = 0, resetn = 0, pin_config = 1, sdram_cmd_valid = 1, edo_cas_active = 0;
    logic row_is_sdram, sdram_read, sdram_write, logical_col_strobe_n, write_enable_n;
    logic col_strobe_mask_dup_lane1_n, col_strobe_mask_dup_lane5_n;
    logic [1:0] cur_socket = 2'h0, next_socket = 2'h0;
    logic [2:0] sdram_cmd = 3'h7, sdram_row_strobe_n;
    logic [7:0] byte_enable, row_select_next = 8'h21, col_strobe_byte_mask_n, shared_copy_pins;
    logic [13:0] primary_mem_addr_next = 14'h0100, primary_mem_addr, row_addr;
    logic [19:0] rows [4] = '{20'hA0FF0, 20'hCC33C, 20'h10000, 20'h8AAFF};
    logic [25:0] cps [4] = '{26'h03FC0FF, 26'h18000FF, 26'h2154055, 26'h34FC055};
    int miscompares = 0, checks_done = 0;
    dsm_strobe_out i_dsm_strobe_out (.*);
    dsm_sdram_model i_dsm_sdram_model (.clk(clk), .row_strobe_n(sdram_row_strobe_n),
        .addr(primary_mem_addr), .row_addr(row_addr));
    always #2.5 clk = ~clk;
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, want);
        checks_done++;
        if (seen !== want) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #20000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        {row_is_sdram, sdram_read, sdram_write, byte_enable} = 11'h0FF;
        repeat (8) step();
        resetn = 1;
        step();
        foreach (rows[i]) begin
            {row_is_sdram, sdram_read, sdram_write, edo_cas_active, byte_enable} = rows[i][19:8];
            step();
            chk(col_strobe_byte_mask_n, rows[i][7:0]);
            chk({col_strobe_mask_dup_lane1_n, col_strobe_mask_dup_lane5_n},
                {rows[i][1], rows[i][5]});
        end
        for (int c = 0; c < 8; c++) begin
            sdram_cmd = c[2:0];
            step();
            chk({sdram_row_strobe_n, logical_col_strobe_n, write_enable_n},
                {{3{c[2]}}, c[1], c[0]});
        end
        step();
        chk(row_addr, 14'h0100);
        foreach (cps[i]) begin
            {cur_socket, next_socket, primary_mem_addr_next} = cps[i][25:8];
            step();
            chk(shared_copy_pins, cps[i][7:0]);
        end
        resetn = 0;
        pin_config = 0;
        {sdram_write, byte_enable} = 9'h122;
        step();
        resetn = 1;
        step();
        pin_config = 1;
        step();
        chk(shared_copy_pins, 8'hDE);
        chk(col_strobe_byte_mask_n, 8'hDD);
        report_and_stop();
    end
endmodule
